/* File: hw/cpu_fifo_port.sv */
// Purpose: Device side of the CPU-style parallel FIFO port
// Assumes: Pins arrive asynchronously; internal buffers run on mclk
// Notes: Address bit 0 selects data, 1 selects the status word
`timescale 1ns/100ps
// Notes on behaviour
// RL1 - Port drives and accepts pins only when configuration selects this mode; power_enable_n is driven in every mode.
// RL2 - Eight-bit two-way data bus; driven on reads, sampled on writes.
// RL3 - Strobes count only while chip select is low.
// RL4 - Low read strobe fetches a byte from the transmit path.
// RL5 - Low write strobe captures the bus byte into the receive path.
// RL6 - Send-immediate low, not suspended, flushes receive data on next bulk-IN.
// RL7 - Power enable output high while suspended, low otherwise.
// RL8 - Address bit picks data FIFO or buffer status word.
module cpu_fifo_port
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Configuration
    input wire logic cpu_mode_sel,
    input wire logic usb_suspended,
    // CPU pins
    input wire logic [cpu_port_pkg::DATA_W-1:0] host_data_bus_in,
    output logic [cpu_port_pkg::DATA_W-1:0] host_data_bus_out,
    output logic host_data_bus_oe,
    input wire logic chip_sel_n,
    input wire logic addr_select_bit,
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic send_now_n,
    output logic power_enable_n,
    // Transmit path from USB (bytes to CPU)
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [cpu_port_pkg::DATA_W-1:0] tx_data,
    // Receive path to USB (bytes from CPU)
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [cpu_port_pkg::DATA_W-1:0] rx_data,
    // Flush request for next bulk-IN
    output logic flush_req
);
    import cpu_port_pkg::*;

    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_READ = 2'b01, ST_WRITE = 2'b11,
        ST_HOLD = 2'b10} port_state_t;

    // Three-stage synchronisers, stage 0 read only by stage 1
    logic [SYNC_STAGES-1:0] cs_s_q;
    logic [SYNC_STAGES-1:0] rd_s_q;
    logic [SYNC_STAGES-1:0] wr_s_q;
    logic [SYNC_STAGES-1:0] si_s_q;
    logic [SYNC_STAGES-1:0] a0_s_q;
    logic [SYNC_STAGES-1:0] cfg_s_q;
    logic cs_q, rd_q, wr_q, si_q, a0_q;
    logic si_prev_q;
    logic susp_q;
    port_state_t state_q, state_d;
    logic [DATA_W-1:0] dout_q, dout_d;
    logic oe_q;
    logic flush_q;
    logic pwr_q;
    logic [DATA_W-1:0] wdata_q;
    logic fifo_in_valid_q;
    logic tx_ready_q;

    function automatic logic agreed(input logic [SYNC_STAGES-1:0] s, input logic old);
        agreed = (s[1] == s[2]) ? s[2] : old;
    endfunction

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cs_s_q <= '1;
            rd_s_q <= '1;
            wr_s_q <= '1;
            si_s_q <= '1;
            a0_s_q <= '0;
            cfg_s_q <= '0;
        end
        else
        begin
            cs_s_q <= {cs_s_q[1:0], chip_sel_n};
            rd_s_q <= {rd_s_q[1:0], rd_strobe_n};
            wr_s_q <= {wr_s_q[1:0], wr_strobe_n};
            si_s_q <= {si_s_q[1:0], send_now_n};
            a0_s_q <= {a0_s_q[1:0], addr_select_bit};
            cfg_s_q <= {cfg_s_q[1:0], cpu_mode_sel};
        end
    end

    // Filtered levels; a change counts once the last two stages agree
    logic cfg_q;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cs_q <= 1'b1;
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            si_q <= 1'b1;
            a0_q <= 1'b0;
            cfg_q <= 1'b0;
            si_prev_q <= 1'b1;
        end
        else
        begin
            cs_q <= agreed(cs_s_q, cs_q);
            rd_q <= agreed(rd_s_q, rd_q);
            wr_q <= agreed(wr_s_q, wr_q);
            si_q <= agreed(si_s_q, si_q);
            a0_q <= agreed(a0_s_q, a0_q);
            cfg_q <= agreed(cfg_s_q, cfg_q);
            si_prev_q <= si_q;
        end
    end

    // Receive FIFO between CPU writes and the USB side
    logic fifo_in_ready;
    byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .mclk(mclk),
        .reset_n(reset_n),
        .in_valid(fifo_in_valid_q),
        .in_ready(fifo_in_ready),
        .in_data(wdata_q),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    wire logic sel = cfg_q && !cs_q; // [RL1] [RL3]
    wire logic rd_req = sel && !rd_q; // [RL4]
    wire logic wr_req = sel && !wr_q && rd_q; // [RL5]
    wire logic data_sel = (a0_q == ADDR_DATA); // [RL8]
    wire logic [DATA_W-1:0] status_word = {4'h0, cfg_q, susp_q, fifo_in_ready, tx_valid};
    wire logic tx_take = (state_q == ST_IDLE) && rd_req && data_sel && tx_valid;
    wire logic rx_push = (state_q == ST_IDLE) && wr_req && data_sel && fifo_in_ready;
    wire logic si_fall = si_prev_q && !si_q && cfg_q && !susp_q; // [RL6]

    assign tx_ready = tx_ready_q;

    always_comb
    begin
        state_d = state_q;
        dout_d = dout_q;
        case (state_q)
            ST_IDLE:
            begin
                if (rd_req)
                begin
                    state_d = ST_READ;
                    dout_d = data_sel ? (tx_valid ? tx_data : DATA_RESET) : status_word; // [RL8]
                end
                else if (wr_req)
                    state_d = ST_WRITE;
            end
            ST_READ:
                if (!rd_req)
                    state_d = ST_HOLD;
            ST_WRITE:
                if (!wr_req)
                    state_d = ST_HOLD;
            ST_HOLD:
                state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            dout_q <= DATA_RESET;
            oe_q <= 1'b0;
            wdata_q <= DATA_RESET;
            fifo_in_valid_q <= 1'b0;
            flush_q <= 1'b0;
            pwr_q <= 1'b1;
            susp_q <= 1'b1;
            tx_ready_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            dout_q <= dout_d;
            oe_q <= rd_req; // [RL2]
            fifo_in_valid_q <= rx_push; // [RL5]
            if (rx_push)
                wdata_q <= host_data_bus_in; // [RL2]
            flush_q <= si_fall; // [RL6]
            susp_q <= usb_suspended;
            pwr_q <= usb_suspended; // [RL7]
            // Registered so the handshake does not ride on tx_valid combinationally
            tx_ready_q <= tx_take; // [RL4]
        end
    end

    assign host_data_bus_out = dout_q;
    assign host_data_bus_oe = oe_q;
    assign flush_req = flush_q;
    assign power_enable_n = pwr_q;

    sequence s_read_start;
        rd_req && state_q == ST_IDLE;
    endsequence

    sequence s_status_start;
        rd_req && state_q == ST_IDLE && a0_q == ADDR_STATUS;
    endsequence

    chk_bus_drive_read: assert property (@(posedge mclk) disable iff (!reset_n)
        s_read_start |=> host_data_bus_oe) else $error("bus not driven on read"); // [RL2]
    chk_no_drive_idle: assert property (@(posedge mclk) disable iff (!reset_n)
        !rd_req |=> !host_data_bus_oe) else $error("bus driven without read"); // [RL4]
    chk_cs_gates_write: assert property (@(posedge mclk) disable iff (!reset_n)
        cs_q |=> !fifo_in_valid_q) else $error("write taken without select"); // [RL3]
    chk_mode_gates_port: assert property (@(posedge mclk) disable iff (!reset_n)
        !cfg_q |=> !host_data_bus_oe && !fifo_in_valid_q) else $error("port active off"); // [RL1]
    chk_write_captures: assert property (@(posedge mclk) disable iff (!reset_n)
        rx_push |=> fifo_in_valid_q && wdata_q == $past(host_data_bus_in))
        else $error("write byte not captured"); // [RL5]
    chk_flush_not_susp: assert property (@(posedge mclk) disable iff (!reset_n)
        flush_req |-> $past(!susp_q)) else $error("flush while suspended"); // [RL6]
    chk_power_follows: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(usb_suspended) |=> power_enable_n) else $error("power enable wrong"); // [RL7]
    chk_power_wakes: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(usb_suspended) |=> !power_enable_n) else $error("power enable stuck"); // [RL7]
    chk_status_read: assert property (@(posedge mclk) disable iff (!reset_n)
        s_status_start |=> host_data_bus_out == $past(status_word))
        else $error("status word not returned"); // [RL8]
    chk_take_once: assert property (@(posedge mclk) disable iff (!reset_n)
        tx_take |=> tx_ready && host_data_bus_out == $past(tx_data))
        else $error("byte take not signalled"); // [RL4]
endmodule

/* File: hw/cpu_port_pkg.sv */
// Purpose: Shared constants for the CPU-style FIFO port
// Assumes: 100 MHz mclk
// Notes: Address bit selects data FIFO or status word
package cpu_port_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam logic ADDR_DATA = 1'b0;
    localparam logic ADDR_STATUS = 1'b1;
    // Status word field positions
    localparam int ST_TX_VALID = 0;
    localparam int ST_RX_SPACE = 1;
    localparam int ST_SUSPEND = 2;
    localparam int ST_ENABLED = 3;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Strobe filter: three stages, last two must agree
    localparam int SYNC_STAGES = 3;
    localparam int CLK_PERIOD_NS = 10;
    localparam int STROBE_MIN_NS = 30;
    localparam int STROBE_MIN_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: hw/byte_fifo.sv */
// Purpose: Small FIFO with valid/ready on both sides
// Assumes: Depth is a power of two
// Notes: Read data come from a register
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // Refused at elaboration: pointer wrap needs a power of two
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin
        $error("byte_fifo depth must be a power of two, at least 2");
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic [AW:0] count_q;
    logic [WIDTH-1:0] out_q;
    logic out_valid_q;
    wire logic push = in_valid && in_ready;
    wire logic empty_mem = (wp_q == rp_q);
    wire logic pop_mem = !empty_mem && (!out_valid_q || out_ready);
    // Output register holds one of the DEPTH words, so it counts too
    wire logic [AW:0] held = (wp_q - rp_q) + {{AW{1'b0}}, out_valid_q};
    assign in_ready = held != (AW+1)'(DEPTH);
    assign out_valid = out_valid_q;
    assign out_data = out_q;
    always_ff @(posedge mclk)
    begin
        if (push)
            mem_q[wp_q[AW-1:0]] <= in_data;
    end
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wp_q <= '0;
            rp_q <= '0;
            out_q <= '0;
            out_valid_q <= 1'b0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + (AW+1)'(1);
            if (pop_mem)
            begin
                rp_q <= rp_q + (AW+1)'(1);
                out_q <= mem_q[rp_q[AW-1:0]];
            end
            if (pop_mem)
                out_valid_q <= 1'b1;
            else if (out_ready)
                out_valid_q <= 1'b0;
            count_q <= held;
        end
    end
    chk_fifo_no_overrun: assert property (@(posedge mclk) disable iff (!reset_n)
        count_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

/* File: tb/cpu_master_model.sv */
// Purpose: Behavioural CPU bus master for the FIFO port
// Assumes: Strobes held 8 mclk cycles low, then 8 high
// Notes: An undriven bus shows the inverse of its last level
`timescale 1ns/100ps
module cpu_master_model
(
    // Clock
    input wire logic mclk,
    // Device side of the bus
    input wire logic [7:0] host_data_bus_out,
    input wire logic host_data_bus_oe,
    // Pins driven by the CPU
    output logic [7:0] host_data_bus_in,
    output logic chip_sel_n,
    output logic addr_select_bit,
    output logic rd_strobe_n,
    output logic wr_strobe_n
);
    logic [7:0] cpu_d = 8'h00;
    logic cpu_oe = 1'b0;
    logic [7:0] last_q = 8'h00;
    initial
    begin
        chip_sel_n = 1'b1;
        addr_select_bit = 1'b0;
        rd_strobe_n = 1'b1;
        wr_strobe_n = 1'b1;
    end
    always @(posedge mclk) last_q <= host_data_bus_in;
    // Floating bus must not pass for held data
    assign host_data_bus_in = host_data_bus_oe ? host_data_bus_out :
        (cpu_oe ? cpu_d : ~last_q);
    task automatic access(input logic wr, input logic cs_n, input logic addr,
        input logic [7:0] wdata, output logic [7:0] rdata, output logic seen_oe);
        @(posedge mclk);
        #1;
        chip_sel_n = cs_n;
        addr_select_bit = addr;
        cpu_d = wdata;
        cpu_oe = wr;
        rd_strobe_n = wr;
        wr_strobe_n = !wr;
        repeat (8) @(posedge mclk);
        rdata = host_data_bus_in;
        seen_oe = host_data_bus_oe;
        #1;
        rd_strobe_n = 1'b1;
        wr_strobe_n = 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        chip_sel_n = 1'b1;
        cpu_oe = 1'b0;
    endtask
endmodule

/* File: tb/cpu_fifo_port_tb_top.sv */
// Purpose: Self-checking bench for the CPU-style FIFO port
// Assumes: 100 MHz mclk, inputs driven 1 ns after the rising edge
// Notes: USB side is modelled by simple monitors in this module
`timescale 1ns/100ps
module cpu_fifo_port_tb_top;
    import cpu_port_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic cpu_mode_sel = 1'b1;
    logic usb_suspended = 1'b0;
    logic send_now_n = 1'b1;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic rx_ready = 1'b0;
    logic [7:0] bus_in, bus_out, rx_data, r;
    logic bus_oe, cs_n, addr, rd_n, wr_n, pwr_n, tx_ready, rx_valid, flush_req, o;
    int bad_count = 0;
    int checks = 0;
    int taken = 0;
    int flushes = 0;
    logic [7:0] got_q[$];
    always #5 mclk = ~mclk;
    cpu_master_model cpu (.mclk(mclk), .host_data_bus_out(bus_out),
        .host_data_bus_oe(bus_oe), .host_data_bus_in(bus_in), .chip_sel_n(cs_n),
        .addr_select_bit(addr), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n));
    cpu_fifo_port dut (.mclk(mclk), .reset_n(reset_n), .cpu_mode_sel(cpu_mode_sel),
        .usb_suspended(usb_suspended), .host_data_bus_in(bus_in),
        .host_data_bus_out(bus_out), .host_data_bus_oe(bus_oe), .chip_sel_n(cs_n),
        .addr_select_bit(addr), .rd_strobe_n(rd_n), .wr_strobe_n(wr_n),
        .send_now_n(send_now_n), .power_enable_n(pwr_n), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data), .flush_req(flush_req));
    always @(posedge mclk)
    begin
        if (tx_ready === 1'b1)
        begin
            taken++;
            tx_valid <= 1'b0;
        end
        if (rx_valid === 1'b1 && rx_ready === 1'b1) got_q.push_back(rx_data);
        if (flush_req === 1'b1) flushes++;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %s got %h", $time, msg, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic test_reset();
        repeat (8) @(posedge mclk);
        check({pwr_n, bus_oe, rx_valid, flush_req}, 8'h08, "reset levels");
        $display("test reset done");
    endtask
    task automatic test_write_fill();
        cpu.access(1'b0, 1'b0, ADDR_STATUS, 8'h00, r, o);
        check(r, 8'h0A, "status empty");
        for (int i = 0; i < 5; i++) cpu.access(1'b1, 1'b0, ADDR_DATA, 8'hA0 + 8'(i), r, o);
        cpu.access(1'b0, 1'b0, ADDR_STATUS, 8'h00, r, o);
        check(r, 8'h08, "status full");
        @(posedge mclk) #1 rx_ready = 1'b1;
        repeat (20) @(posedge mclk);
        check(8'(got_q.size()), 8'h04, "rx count, fifth dropped");
        for (int i = 0; i < 4; i++) check(got_q[i], 8'hA0 + 8'(i), "rx byte");
        got_q.delete();
        $display("test write fill done");
    endtask
    task automatic test_read();
        #1 tx_data = 8'h3C;
        tx_valid = 1'b1;
        cpu.access(1'b0, 1'b0, ADDR_STATUS, 8'h00, r, o);
        check(r, 8'h0B, "status tx valid");
        check(8'(taken), 8'h00, "status read took byte");
        cpu.access(1'b0, 1'b0, ADDR_DATA, 8'h00, r, o);
        check(r, 8'h3C, "read byte");
        check({7'h00, o}, 8'h01, "bus driven on read");
        check({7'h00, bus_oe}, 8'h00, "bus released");
        check(8'(taken), 8'h01, "tx taken once");
        cpu.access(1'b0, 1'b0, ADDR_DATA, 8'h00, r, o);
        check(r, 8'h00, "read empty");
        $display("test read done");
    endtask
    task automatic test_refuse();
        @(posedge mclk) #1 tx_valid = 1'b1;
        cpu.access(1'b1, 1'b1, ADDR_DATA, 8'h55, r, o);
        cpu.access(1'b0, 1'b1, ADDR_DATA, 8'h00, r, o);
        check({7'h00, o}, 8'h00, "drive without select");
        @(posedge mclk) #1 cpu_mode_sel = 1'b0;
        repeat (8) @(posedge mclk);
        cpu.access(1'b1, 1'b0, ADDR_DATA, 8'h66, r, o);
        cpu.access(1'b0, 1'b0, ADDR_DATA, 8'h00, r, o);
        check({7'h00, o}, 8'h00, "drive in other mode");
        repeat (20) @(posedge mclk);
        check(8'(got_q.size()), 8'h00, "ignored writes");
        check(8'(taken), 8'h01, "ignored reads");
        #1 cpu_mode_sel = 1'b1;
        tx_valid = 1'b0;
        repeat (8) @(posedge mclk);
        $display("test refuse done");
    endtask
    task automatic test_send_now();
        for (int s = 0; s < 2; s++)
        begin
            #1 usb_suspended = 1'(s);
            repeat (4) @(posedge mclk);
            check({7'h00, pwr_n}, 8'(s), "power enable level");
            #1 send_now_n = 1'b0;
            repeat (8) @(posedge mclk);
            #1 send_now_n = 1'b1;
            repeat (12) @(posedge mclk);
            check(8'(flushes), 8'h01, "flush count");
        end
        #1 usb_suspended = 1'b0;
        $display("test send now done");
    endtask
    initial
    begin
        #100000;
        bad_count++;
        print_verdict();
    end
    initial
    begin
        test_reset();
        repeat (8) @(posedge mclk);
        #1 reset_n = 1'b1;
        repeat (8) @(posedge mclk);
        test_write_fill();
        test_read();
        test_refuse();
        test_send_now();
        print_verdict();
    end
endmodule
